// ---- dv/parallel_peripheral.sv ----
// far-side peripheral: acknowledges output bytes, strobes input bytes
`timescale 1ns/10ps
`default_nettype none
module parallel_peripheral
  import port_bank_pkg::*;
(
  // clock
  input  wire logic                        hclk,
  // pins and strobe request
  input  wire port_lines_t [NUM_BANKS-1:0] lines_out,
  input  wire logic                        go,
  input  wire logic [7:0]                  sd,
  output wire port_lines_t [NUM_BANKS-1:0] lines_in
);
  // ---------------------------------------------------------------
  // handshakes, phases at least 2 cycles
  // ---------------------------------------------------------------
  logic [7:0] cnt = 8'h00;
  logic [7:0] a_q = 8'h00;
  logic       ack_n = 1'b1;
  logic       stb_n = 1'b1;
  always @(posedge hclk) cnt <= cnt + 8'h01;
  assign lines_in = {{3{cnt, ~cnt, cnt}}, a_q, cnt, 1'b0, ack_n, 1'b0, stb_n, go, 3'h0};
  initial forever begin
    @(negedge lines_out[0].c[7]);
    repeat (2 + $urandom_range(3)) @(posedge hclk);
    ack_n <= 1'b0;
    repeat (3) @(posedge hclk);
    ack_n <= 1'b1;
  end
  initial forever begin
    @(posedge hclk iff go);
    a_q <= sd;
    stb_n <= 1'b0;
    repeat (3) @(posedge hclk);
    stb_n <= 1'b1;
    @(posedge hclk);
    a_q <= ~sd;
  end
endmodule
`default_nettype wire

// ---- dv/strobed_port_handshake_irq_bench.sv ----
// self-checking bench for the handshake port banks
`timescale 1ns/10ps
`default_nettype none
module strobed_port_handshake_irq_bench import port_bank_pkg::*;;
  // ---------------------------------------------------------------
  // signals, tasks and sequence
  // ---------------------------------------------------------------
  localparam logic [6:0] ST = 7'h08;
  localparam logic [6:0] CF = 7'h0C;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, go = 1'b0, rd_ph = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [7:0] sd = 8'h00, d, v;
  logic hreadyout, hresp, host_irq;
  logic [15:0] e, exp_q[$];
  port_lines_t [NUM_BANKS-1:0] lines_in, lines_out, lines_oe;
  int bad_count = 0, n_tests = 0;
  strobed_port_handshake_irq dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .lines_in, .lines_out, .lines_oe, .host_irq);
  parallel_peripheral peer_u (.hclk, .lines_out, .go, .sd, .lines_in);
  initial forever #12.5 hclk = ~hclk;
  task automatic wrap_up;
    if (bad_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] ex);
    n_tests++;
    if (got !== ex) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, ex);
    end
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin bad_count++; wrap_up; end
      @(posedge hclk);
    end
  endtask
  task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] dat, input logic [15:0] ex);
    hsel <= 1'b1;
    haddr <= {25'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, dat};
    if (!w) exp_q.push_back(ex);
    wait_rdy;
    d = hrdata[7:0];
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] dat);
    xfer(1'b1, a, dat, 16'h0000);
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] ex);
    xfer(1'b0, a, 8'h00, ex);
  endtask
  task automatic irq(input logic x);
    chk({7'h00, host_irq}, {7'h00, x});
  endtask
  task automatic poll(input logic [7:0] m);
    int n;
    n = 0;
    do begin rd(ST, 16'h0000); n++; end while ((d & m) !== m && n < 40);
    if ((d & m) !== m) begin bad_count++; wrap_up; end
  endtask
  always @(posedge hclk) begin
    if (rd_ph && hreadyout === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (e[15:8] != 8'h00) chk(hrdata[7:0] & e[15:8], e[7:0]);
    end
    if (hreadyout) rd_ph <= hsel & htrans[1] & !hwrite;
  end
  initial begin
    v = 8'($urandom(32'h6928EA0E));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rd(CF, 16'hFF9B);
    rd(7'h4C, 16'hFF00);
    wr(7'h48, 8'h00);
    wr(CF, 8'hA0);
    wr(CF, 8'h0D);
    rd(ST, 16'hFFC8);
    chk(lines_oe[0].c, 8'hBF);
    chk(lines_oe[0].a, 8'hFF);
    wr(7'h44, 8'h04);
    wr(7'h40, 8'h01);
    repeat (2) @(posedge hclk);
    irq(1'b1);
    for (int i = 0; i < 3; i++) begin
      v = 8'($urandom);
      wr(7'h00, v);
      rd(ST, 16'hC840);
      chk(lines_out[0].a, v);
      irq(1'b0);
      poll(8'h88);
      irq(1'b1);
    end
    wr(7'h40, 8'h00);
    repeat (2) @(posedge hclk);
    irq(1'b0);
    wr(CF, 8'h0E);
    wr(CF, 8'h0B);
    rd(ST, 16'hFFE8);
    chk({7'h00, lines_out[0].c[5]}, 8'h01);
    wr(CF, 8'hC0);
    wr(CF, 8'h09);
    wr(CF, 8'h0D);
    rd(ST, 16'hFFD8);
    chk(lines_oe[0].c, 8'hAF);
    chk(lines_oe[0].a, 8'h00);
    v = 8'($urandom);
    sd <= v;
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    poll(8'h28);
    rd(7'h00, {8'hFF, v});
    rd(ST, 16'h2000);
    wr(CF, 8'h81);
    wr(7'h40, 8'h01);
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    repeat (5) @(posedge hclk);
    irq(1'b1);
    rd(7'h48, 16'h0101);
    wr(7'h48, 8'h00);
    repeat (2) @(posedge hclk);
    irq(1'b0);
    rd(7'h48, 16'h0100);
    wr(CF, 8'h84);
    wr(CF, 8'h05);
    rd(ST, 16'hFF07);
    wr(7'h04, v);
    rd(ST, 16'h0704);
    wrap_up;
  end
endmodule
`default_nettype wire

// ---- dv/strobed_port_handshake_irq_props.sv ----
// bus, handshake pin and board interrupt assertions
`timescale 1ns/10ps
`default_nettype none
module strobed_port_handshake_irq_props
  import port_bank_pkg::*;
(
  // clock and reset
  input wire logic                        hclk,
  input wire logic                        hresetn,
  // bus
  input wire logic                        hsel,
  input wire logic [BUS_W-1:0]            haddr,
  input wire logic [1:0]                  htrans,
  input wire logic                        hwrite,
  input wire logic [2:0]                  hsize,
  input wire logic [BUS_W-1:0]            hwdata,
  input wire logic                        hready,
  input wire logic [BUS_W-1:0]            hrdata,
  input wire logic                        hreadyout,
  input wire logic                        hresp,
  // lines and interrupt
  input wire port_lines_t [NUM_BANKS-1:0] lines_in,
  input wire port_lines_t [NUM_BANKS-1:0] lines_out,
  input wire port_lines_t [NUM_BANKS-1:0] lines_oe,
  input wire logic                        host_irq
);
  // ---------------------------------------------------------------
  // shadow of bus writes
  // ---------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic       ap_v, ap_w, men_q;
  logic [4:0] ap_i;
  logic [7:0] cfg_q;
  wire logic  take   = hsel & htrans[1] & hready;
  wire logic  wr_now = ap_v & ap_w & hready;
  wire logic  a_m1   = cfg_q[6:5] == 2'h1;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) {ap_v, ap_w, ap_i} <= '0;
    else if (hready) {ap_v, ap_w, ap_i} <= {take, hwrite, haddr[6:2]};
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) {men_q, cfg_q} <= {1'b0, CFG_RESET};
    else if (wr_now && ap_i == IDX_IRQ_TWO) men_q <= hwdata[MASTER_EN_BIT];
    else if (wr_now && ap_i == 5'h03 && hwdata[7]) cfg_q <= hwdata[7:0];
  okay_resp_a: assert property (hresp == 1'b0) else $error("error response");
  read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait");
  write_fast_a: assert property (take && hwrite |=> hreadyout) else $error("write stalled");
  unmapped_a: assert property (take && !hwrite && haddr[6:2] > IDX_IRQ_CLEAR |-> ##2 hrdata == '0)
    else $error("unmapped read not zero");
  upper_zero_a: assert property (hreadyout |-> hrdata[31:8] == 24'h0) else $error("upper read bits set");
  obf_low_a: assert property (wr_now && ap_i == 5'h00 && a_m1 |=> ##[0:1] !lines_out[0].c[7])
    else $error("buffer full flag not low");
  ack_clear_a: assert property (a_m1 && $fell(lines_in[0].c[6]) |-> ##[2:6] lines_out[0].c[7])
    else $error("buffer full flag not released");
  irq_gate_a: assert property (host_irq |-> $past(men_q)) else $error("interrupt without master enable");
  rd_c: cover property (take && !hwrite);
  irq_c: cover property ($rose(host_irq));
  ack_c: cover property (a_m1 && $fell(lines_in[0].c[6]));
endmodule
bind strobed_port_handshake_irq strobed_port_handshake_irq_props chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .lines_in, .lines_out, .lines_oe, .host_irq);
`default_nettype wire

// ---- logic/level_edge.sv ----
// rise and fall detector on synchronised levels
`timescale 1ns/10ps
`default_nettype none
module level_edge #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // levels and edges
  input  wire logic [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] prev_reg;
  logic [1:0]       fill_reg;
  logic             armed;

  // edges held off until synchroniser and this stage carry real pin levels
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fill_reg <= '0;
    end else if (!armed) begin
      fill_reg <= fill_reg + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= level;
    end
  end

  assign armed = &fill_reg;
  assign rise  = level & ~prev_reg & {WIDTH{armed}};
  assign fall  = prev_reg & ~level & {WIDTH{armed}};

endmodule
`default_nettype wire

// ---- logic/port_bank_pkg.sv ----
// shared constants and types for the handshake port banks
package port_bank_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int NUM_BANKS   = 4;
  localparam int LINE_W      = 8;
  localparam int ADDR_IDX_W  = 5;
  localparam int BUS_W       = 32;

  // ---------------------------------------------------------------
  // register indices (byte address = index * 4)
  // ---------------------------------------------------------------
  localparam logic [4:0] STATUS_IDX_BANK_A = 5'h02;
  localparam logic [4:0] STATUS_IDX_BANK_B = 5'h06;
  localparam logic [4:0] STATUS_IDX_BANK_C = 5'h0A;
  localparam logic [4:0] STATUS_IDX_BANK_D = 5'h0E;
  localparam logic [1:0] SUB_PORT_A        = 2'h0;
  localparam logic [1:0] SUB_PORT_B        = 2'h1;
  localparam logic [1:0] SUB_STATUS        = STATUS_IDX_BANK_A[1:0];
  localparam logic [1:0] SUB_CONFIG        = 2'h3;
  localparam logic [4:0] IDX_BANK_LIMIT    = 5'h10;
  localparam logic [4:0] IDX_IRQ_ONE       = 5'h10;
  localparam logic [4:0] IDX_IRQ_TWO       = 5'h11;
  localparam logic [4:0] IDX_IRQ_CLEAR     = 5'h12;
  localparam int         IDX_BANK_LSB      = 2;
  localparam int         IDX_BANK_MSB      = 3;
  localparam int         ADDR_IDX_LSB      = 2;

  // ---------------------------------------------------------------
  // configuration word
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       mode_set;
    logic [1:0] a_mode;
    logic       a_in;
    logic       cu_in;
    logic       b_mode;
    logic       b_in;
    logic       cl_in;
  } config_t;

  localparam logic [7:0] CFG_RESET      = 8'h9B;
  localparam int         CFG_MODE_BIT   = 7;
  localparam logic [1:0] A_MODE_BASIC   = 2'h0;
  localparam int         A_MODE_BIDIR   = 1;
  localparam int         BSR_LINE_LSB   = 1;
  localparam int         BSR_LINE_MSB   = 3;
  localparam int         BSR_VAL_BIT    = 0;

  // ---------------------------------------------------------------
  // port c line roles
  // ---------------------------------------------------------------
  localparam logic [2:0] LINE_A_OUT_EN  = 3'h6;
  localparam logic [2:0] LINE_A_IN_EN   = 3'h4;
  localparam logic [2:0] LINE_B_EN      = 3'h2;
  localparam int         ACK_A_LINE     = 6;
  localparam int         STB_A_LINE     = 4;
  localparam int         ACK_B_LINE     = 2;
  localparam int         EXT0_LINE      = 3;
  localparam int         EXT1_LINE      = 0;
  localparam logic [7:0] HS_OE_MASK     = 8'hAB;

  // ---------------------------------------------------------------
  // interrupt control
  // ---------------------------------------------------------------
  localparam int         MASTER_EN_BIT  = 2;
  localparam logic [7:0] IRQ_ONE_RESET  = 8'h00;

  // ---------------------------------------------------------------
  // pin groups of one bank
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] c;
  } port_lines_t;

endpackage

// ---- logic/strobed_port_handshake_irq.sv ----
// four handshake port banks with status words and board interrupt, ahb-lite slave
// ---------------------------------------------------------------
// ---------------------------------------------------------------
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module strobed_port_handshake_irq
  import port_bank_pkg::*;
(
  // clock and reset
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  // ahb-lite slave
  input  wire logic                          hsel,
  input  wire logic [BUS_W-1:0]              haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [BUS_W-1:0]              hwdata,
  input  wire logic                          hready,
  output logic      [BUS_W-1:0]              hrdata,
  output logic                               hreadyout,
  output logic                               hresp,
  // parallel lines
  input  wire port_lines_t [NUM_BANKS-1:0]   lines_in,
  output port_lines_t      [NUM_BANKS-1:0]   lines_out,
  output port_lines_t      [NUM_BANKS-1:0]   lines_oe,
  // host interrupt
  output logic                               host_irq
);

  // ---------------------------------------------------------------
  // bus phase tracking
  // ---------------------------------------------------------------
  logic [ADDR_IDX_W-1:0]            addr_reg;
  logic                             wr_pend_reg;
  logic                             rd_pend_reg;
  logic                             hreadyout_reg;
  logic [BUS_W-1:0]                 hrdata_reg;
  logic                             accept;
  logic [7:0]                       wbyte;
  logic                             in_bank;
  logic [1:0]                       sel_bank;
  logic [1:0]                       sel_sub;
  logic [7:0]                       rd_byte;
  logic [NUM_BANKS-1:0][7:0]        status_rd;
  logic [NUM_BANKS-1:0][7:0]        pa_rd;
  logic [NUM_BANKS-1:0][7:0]        pb_rd;
  logic [NUM_BANKS-1:0][7:0]        cfg_rd;
  logic [2*NUM_BANKS-1:0]           sources;
  logic [2*NUM_BANKS-1:0]           ext_pend_all;
  logic [7:0]                       irq_one_reg;
  logic                             master_reg;
  logic                             host_irq_reg;
  logic                             wr_irq_clear;
  port_lines_t [NUM_BANKS-1:0]      lines_sync;

  assign accept   = hsel & htrans[1] & hready;
  assign wbyte    = hwdata[7:0];
  assign in_bank  = addr_reg < IDX_BANK_LIMIT;
  assign sel_bank = addr_reg[IDX_BANK_MSB:IDX_BANK_LSB];
  assign sel_sub  = addr_reg[1:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_reg    <= '0;
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
    end else begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      if (accept) begin
        addr_reg    <= haddr[ADDR_IDX_LSB+ADDR_IDX_W-1:ADDR_IDX_LSB];
        wr_pend_reg <= hwrite;
        rd_pend_reg <= ~hwrite;
      end
    end
  end

  // reads take one wait state so the data comes from a flip-flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_reg <= 1'b1;
    end else if (accept && !hwrite) begin
      hreadyout_reg <= 1'b0;
    end else if (rd_pend_reg) begin
      hreadyout_reg <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= '0;
    end else if (rd_pend_reg) begin
      hrdata_reg <= {{(BUS_W-8){1'b0}}, rd_byte};
    end
  end

  // ---------------------------------------------------------------
  // read decode
  // ---------------------------------------------------------------
  always_comb begin
    rd_byte = 8'h00;
    if (in_bank) begin
      if (sel_sub == SUB_PORT_A) begin
        rd_byte = pa_rd[sel_bank];
      end else if (sel_sub == SUB_PORT_B) begin
        rd_byte = pb_rd[sel_bank];
      end else if (sel_sub == SUB_STATUS) begin
        rd_byte = status_rd[sel_bank];
      end else begin
        rd_byte = cfg_rd[sel_bank];
      end
    end else if (addr_reg == IDX_IRQ_ONE) begin
      rd_byte = irq_one_reg;
    end else if (addr_reg == IDX_IRQ_TWO) begin
      rd_byte = 8'(master_reg) << MASTER_EN_BIT;
    end else if (addr_reg == IDX_IRQ_CLEAR) begin
      rd_byte = ext_pend_all;
    end
  end

  // ---------------------------------------------------------------
  // interrupt control
  // ---------------------------------------------------------------
  assign wr_irq_clear = wr_pend_reg & (addr_reg == IDX_IRQ_CLEAR);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_one_reg <= IRQ_ONE_RESET;
      master_reg  <= 1'b0;
    end else if (wr_pend_reg && addr_reg == IDX_IRQ_ONE) begin
      irq_one_reg <= wbyte;
    end else if (wr_pend_reg && addr_reg == IDX_IRQ_TWO) begin
      master_reg <= wbyte[MASTER_EN_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      host_irq_reg <= 1'b0;
    end else begin
      host_irq_reg <= master_reg & (|(irq_one_reg & sources));
    end
  end

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  sync_stage #(
    .WIDTH($bits(port_lines_t) * NUM_BANKS)
  ) u_sync (
    .clk      (hclk),
    .rst_n    (hresetn),
    .async_in (lines_in),
    .sync_out (lines_sync)
  );

  // ---------------------------------------------------------------
  // per-bank handshake logic
  // ---------------------------------------------------------------
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    config_t    cfg_reg;
    logic [7:0] pa_out_reg;
    logic [7:0] pb_out_reg;
    logic [7:0] pc_latch_reg;
    logic [7:0] a_in_latch_reg;
    logic [7:0] pc_out_reg;
    logic [7:0] pc_oe_reg;
    logic       pa_oe_reg;
    logic       pb_oe_reg;
    logic       a_obf_n_reg;
    logic       a_ibf_reg;
    logic       a_out_done_reg;
    logic       a_in_done_reg;
    logic       b_obf_n_reg;
    logic       b_out_done_reg;
    logic       a_out_en_reg;
    logic       a_in_en_reg;
    logic       b_en_reg;
    logic [1:0] ext_pend_reg;
    logic       here;
    logic       wr_a;
    logic       wr_b;
    logic       wr_c;
    logic       wr_cfg;
    logic       rd_a;
    logic       mode_set;
    logic       bsr;
    logic [2:0] bsr_line;
    logic       bsr_val;
    logic       ah;
    logic       abd;
    logic       bh;
    logic       a_req;
    logic       b_req;
    logic [7:0] own;
    logic [7:0] hs_val;
    logic [7:0] st_val;
    logic [7:0] gpio_in;
    logic [7:0] gpio_rd;
    logic [7:0] c_rise;
    logic [7:0] c_fall;

    level_edge #(
      .WIDTH(LINE_W)
    ) u_edge (
      .clk   (hclk),
      .rst_n (hresetn),
      .level (lines_sync[b].c),
      .rise  (c_rise),
      .fall  (c_fall)
    );

    assign here     = in_bank & (sel_bank == 2'(b));
    assign wr_a     = wr_pend_reg & here & (sel_sub == SUB_PORT_A);
    assign wr_b     = wr_pend_reg & here & (sel_sub == SUB_PORT_B);
    assign wr_c     = wr_pend_reg & here & (sel_sub == SUB_STATUS);
    assign wr_cfg   = wr_pend_reg & here & (sel_sub == SUB_CONFIG);
    assign rd_a     = rd_pend_reg & here & (sel_sub == SUB_PORT_A);
    assign mode_set = wr_cfg & wbyte[CFG_MODE_BIT];
    assign bsr      = wr_cfg & ~wbyte[CFG_MODE_BIT];
    assign bsr_line = wbyte[BSR_LINE_MSB:BSR_LINE_LSB];
    assign bsr_val  = wbyte[BSR_VAL_BIT];

    assign ah  = cfg_reg.a_mode != A_MODE_BASIC;
    assign abd = cfg_reg.a_mode[A_MODE_BIDIR];
    assign bh  = cfg_reg.b_mode;

    // request flags exist only behind their enables
    assign a_req = ah & ((a_out_en_reg & a_out_done_reg)
                 | (abd & a_in_en_reg & a_in_done_reg));
    assign b_req = bh & b_en_reg & b_out_done_reg;

    // lines taken over by handshakes
    assign own     = {ah, ah, abd, abd, ah, bh, bh, bh};
    assign hs_val  = {a_obf_n_reg, 1'b0, a_ibf_reg, 1'b0, a_req, 1'b0, b_obf_n_reg, b_req};
    assign st_val  = {a_obf_n_reg, a_out_en_reg, a_ibf_reg, a_in_en_reg,
                      a_req, b_en_reg, b_obf_n_reg, b_req};
    assign gpio_in = {{4{cfg_reg.cu_in}}, {4{cfg_reg.cl_in}}};
    assign gpio_rd = (gpio_in & lines_sync[b].c) | (~gpio_in & pc_latch_reg);

    // strobe and acknowledge levels never reach the status word
    assign status_rd[b] = (own & st_val) | (~own & gpio_rd);
    assign cfg_rd[b]    = cfg_reg;
    assign pa_rd[b]     = abd ? a_in_latch_reg
                        : ((ah | ~cfg_reg.a_in) ? pa_out_reg : lines_sync[b].a);
    assign pb_rd[b]     = (bh | ~cfg_reg.b_in) ? pb_out_reg : lines_sync[b].b;

    assign sources[2*b]        = a_req | ext_pend_reg[0];
    assign sources[2*b+1]      = b_req | ext_pend_reg[1];
    assign ext_pend_all[2*b]   = ext_pend_reg[0];
    assign ext_pend_all[2*b+1] = ext_pend_reg[1];

    assign lines_out[b] = '{a: pa_out_reg, b: pb_out_reg, c: pc_out_reg};
    assign lines_oe[b]  = '{a: {LINE_W{pa_oe_reg}}, b: {LINE_W{pb_oe_reg}}, c: pc_oe_reg};

    // configuration word
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        cfg_reg <= config_t'(CFG_RESET);
      end else if (mode_set) begin
        cfg_reg <= config_t'(wbyte);
      end
    end

    // request enables through bit set/reset
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        a_out_en_reg <= 1'b0;
        a_in_en_reg  <= 1'b0;
        b_en_reg     <= 1'b0;
      end else if (mode_set) begin
        a_out_en_reg <= 1'b0;
        a_in_en_reg  <= 1'b0;
        b_en_reg     <= 1'b0;
      end else if (bsr && own[bsr_line]) begin
        if (bsr_line == LINE_A_OUT_EN) begin
          a_out_en_reg <= bsr_val;
        end else if (bsr_line == LINE_A_IN_EN) begin
          a_in_en_reg <= bsr_val;
        end else if (bsr_line == LINE_B_EN) begin
          b_en_reg <= bsr_val;
        end
      end
    end

    // general-purpose port c latch
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        pc_latch_reg <= 8'h00;
      end else if (mode_set) begin
        pc_latch_reg <= 8'h00;
      end else if (bsr && !own[bsr_line]) begin
        pc_latch_reg[bsr_line] <= bsr_val;
      end else if (wr_c) begin
        pc_latch_reg <= (pc_latch_reg & own) | (wbyte & ~own);
      end
    end

    // port a output and input handshakes
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        pa_out_reg     <= 8'h00;
        a_in_latch_reg <= 8'h00;
        a_obf_n_reg    <= 1'b1;
        a_ibf_reg      <= 1'b0;
        a_out_done_reg <= 1'b1;
        a_in_done_reg  <= 1'b0;
      end else if (mode_set) begin
        pa_out_reg     <= 8'h00;
        a_obf_n_reg    <= 1'b1;
        a_ibf_reg      <= 1'b0;
        a_out_done_reg <= 1'b1;
        a_in_done_reg  <= 1'b0;
      end else begin
        if (wr_a) begin
          pa_out_reg <= wbyte;
          if (ah) begin
            a_obf_n_reg    <= 1'b0;
            a_out_done_reg <= 1'b0;
          end
        end
        if (rd_a && abd) begin
          a_ibf_reg     <= 1'b0;
          a_in_done_reg <= 1'b0;
        end
        if (ah && c_fall[ACK_A_LINE]) begin
          a_obf_n_reg <= 1'b1;
        end
        if (ah && c_rise[ACK_A_LINE]) begin
          a_out_done_reg <= 1'b1;
        end
        if (abd && c_fall[STB_A_LINE]) begin
          a_in_latch_reg <= lines_sync[b].a;
          a_ibf_reg      <= 1'b1;
        end
        if (abd && c_rise[STB_A_LINE]) begin
          a_in_done_reg <= 1'b1;
        end
      end
    end

    // port b output handshake
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        pb_out_reg     <= 8'h00;
        b_obf_n_reg    <= 1'b1;
        b_out_done_reg <= 1'b1;
      end else if (mode_set) begin
        pb_out_reg     <= 8'h00;
        b_obf_n_reg    <= 1'b1;
        b_out_done_reg <= 1'b1;
      end else begin
        if (wr_b) begin
          pb_out_reg <= wbyte;
          if (bh) begin
            b_obf_n_reg    <= 1'b0;
            b_out_done_reg <= 1'b0;
          end
        end
        if (bh && c_fall[ACK_B_LINE]) begin
          b_obf_n_reg <= 1'b1;
        end
        if (bh && c_rise[ACK_B_LINE]) begin
          b_out_done_reg <= 1'b1;
        end
      end
    end

    // external line requests, set wins over clear
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        ext_pend_reg <= 2'b00;
      end else begin
        if (wr_irq_clear || mode_set) begin
          ext_pend_reg <= 2'b00;
        end
        if (!ah && cfg_reg.cl_in && c_rise[EXT0_LINE]) begin
          ext_pend_reg[0] <= 1'b1;
        end
        if (!bh && cfg_reg.cl_in && c_rise[EXT1_LINE]) begin
          ext_pend_reg[1] <= 1'b1;
        end
      end
    end

    // pin drivers
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        pc_out_reg <= 8'h00;
        pc_oe_reg  <= 8'h00;
        pa_oe_reg  <= 1'b0;
        pb_oe_reg  <= 1'b0;
      end else begin
        pc_out_reg <= (own & hs_val) | (~own & pc_latch_reg);
        pc_oe_reg  <= (own & HS_OE_MASK) | (~own & ~gpio_in);
        pa_oe_reg  <= abd ? ~lines_sync[b].c[ACK_A_LINE] : (ah | ~cfg_reg.a_in);
        pb_oe_reg  <= bh | ~cfg_reg.b_in;
      end
    end
  end

  assign hrdata    = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp     = 1'b0;
  assign host_irq  = host_irq_reg;

endmodule
`default_nettype wire

// ---- logic/sync_stage.sv ----
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module sync_stage #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule
`default_nettype wire
